//--- pkg/oaf_regs.svh
// Constants of the operand address formation block: widths, field positions, codes.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef OAF_REGS_SVH
`define OAF_REGS_SVH
`define OAF_ADDR_W      19
`define OAF_CHAR_W      6
`define OAF_BANK_LSB    12
`define OAF_SECT_LSB    15
`define OAF_MAX_INSTR   4'hC
`define OAF_MOD3_DIRECT 3'h0
`define OAF_MOD3_INDIR  3'h7
`define OAF_MOD5_DIRECT 5'h00
`define OAF_MOD5_INDIR  5'h10
`define OAF_RESET_ADDR  19'h00000
`endif

//--- pkg/oaf_pkg.sv
// Types of the operand address formation block.
// Assumes oaf_regs.svh is on the include path.
`include "oaf_regs.svh"
package oaf_pkg;
  typedef enum logic [1:0] {OAF_MODE_2CH, OAF_MODE_3CH, OAF_MODE_4CH} oaf_mode_t;
  typedef enum logic [1:0] {OAF_FORM_DIRECT, OAF_FORM_INDIRECT, OAF_FORM_INDEXED,
                            OAF_FORM_NONE} oaf_form_t;
  typedef enum logic [1:0] {OAF_STEP_NONE, OAF_STEP_UP, OAF_STEP_DOWN} oaf_step_t;
endpackage : oaf_pkg

//--- pkg/oaf_step_if.sv
// Carrier between the top and the stepper: current value, mode, direction, result.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`include "oaf_regs.svh"
interface oaf_step_if;
  logic [`OAF_ADDR_W-1:0] cur;
  oaf_pkg::oaf_mode_t     mode;
  oaf_pkg::oaf_step_t     dir;
  logic                   chan;
  logic [`OAF_ADDR_W-1:0] nxt;
  modport top  (output cur, output mode, output dir, output chan, input nxt);
  modport step (input cur, input mode, input dir, input chan, output nxt);
endinterface : oaf_step_if

//--- design/oaf_stepper.sv
// Combinational address stepper with bank or sector wrap.
// Assumes inputs are settled within the ref_clk cycle.
`timescale 1ns/1ps
`include "oaf_regs.svh"
module oaf_stepper (
  oaf_step_if.step s
);
  wire [`OAF_ADDR_W-1:0] full_up;
  wire [`OAF_ADDR_W-1:0] full_dn;
  wire [`OAF_ADDR_W-1:0] stepped;
  wire [`OAF_ADDR_W-1:0] keep_mask;
  wire                   wrap_all;

  // Whole register steps for channel cycles or four-character mode
  assign full_up  = s.cur + 19'h00001;
  assign full_dn  = s.cur - 19'h00001;
  assign wrap_all = s.chan || (s.mode == oaf_pkg::OAF_MODE_4CH);
  // Bits above the low field are kept; no carry or borrow reaches them
  assign keep_mask = (s.mode == oaf_pkg::OAF_MODE_2CH) ?
                     {{(`OAF_ADDR_W-`OAF_BANK_LSB){1'b1}}, {`OAF_BANK_LSB{1'b0}}} :
                     {{(`OAF_ADDR_W-`OAF_SECT_LSB){1'b1}}, {`OAF_SECT_LSB{1'b0}}};
  assign stepped = (s.dir == oaf_pkg::OAF_STEP_UP) ? full_up : full_dn;
  assign s.nxt = (s.dir == oaf_pkg::OAF_STEP_NONE) ? s.cur :
                 wrap_all ? stepped :
                 ((s.cur & keep_mask) | (stepped & ~keep_mask));
endmodule : oaf_stepper

//--- design/oaf_addr_top.sv
// Operand address formation: mode state, sequence counter, A and B operand registers.
// Assumes an extraction sequencer that presents one instruction character per strobe,
// and an executor that strobes one step per operand character handled.
// Assumes every strobe comes from logic on ref_clk, so no input needs a synchroniser.
// Assumes the mode does not change while an address portion is being assembled.
// Register width is fixed at the largest memory; smaller memories ignore top bits.
// Named constants live in the shared header; the package holds only the types.
//
// Overview of operation
// - Items step up per character reading left to right, down reading right to left.
// - Extended move of a field left to right increments the address register.
// - Extended move of a record right to left decrements the address register.
// - Control registers hold the largest memory address: 12 to 19 bits, here 19.
// - Instructions span 1 to 12 six-bit characters; op code and variants one each.
// - Address portion length follows mode two, three or four characters.
// - Two-character address is one continuous 12-bit binary location 0 to 4095.
// - Two-character extraction writes low 12 bits, keeping bank bits.
// - Only the duplicates-A path overwrites the whole register for short addresses.
// - Execution uses the whole register, bank bits forming a base.
// - Two-character stepping wraps the low 12 bits without touching bank bits.
// - Peripheral channel cycles step all register bits.
// - No indexing or indirection in two-character mode.
// - Three-character address: top three bits modifier, low 15 bits location.
// - Three-character extraction loads low 15 bits; execution uses whole register.
// - Three-character stepping wraps the low 15 bits within one sector.
// - Four-character address: top five bits modifier, low 19 bits address.
// - Four-character extraction loads everything; stepping touches every bit.
// - With advanced programming, modifiers are decoded during extraction.
// - Sequence counter advances by one per instruction character fetched.
// - Field or rightmost-addressed operands decrement the A register per character.
// - Three-bit modifier: 000 direct, 111 indirect, 001 to 110 indexed.
// - Five-bit modifier: 00000 direct, 10000 indirect, others indexed.
`timescale 1ns/1ps
`include "oaf_regs.svh"
module oaf_addr_top (
  input  wire logic                   ref_clk,
  input  wire logic                   resetn,
  // Mode change from the change-addressing-mode instruction
  input  wire logic                   mode_wr,
  input  wire oaf_pkg::oaf_mode_t     mode_in,
  input  wire logic                   adv_prog_en,
  // Instruction character fetch
  input  wire logic                   seq_load,
  input  wire logic [`OAF_ADDR_W-1:0] seq_load_val,
  input  wire logic                   char_fetch,
  input  wire logic                   op_start,
  // Address character delivery during extraction
  input  wire logic                   addr_char_vld,
  input  wire logic [`OAF_CHAR_W-1:0] addr_char,
  input  wire logic                   addr_sel_b,
  input  wire logic                   dup_a,
  // Execution stepping
  input  wire logic                   step_a,
  input  wire logic                   step_b,
  input  wire logic                   step_up,
  input  wire logic                   chan_cycle,
  // Outputs
  output logic [`OAF_ADDR_W-1:0]      instruction_sequence_counter,
  output logic [`OAF_ADDR_W-1:0]      a_operand_address_reg,
  output logic [`OAF_ADDR_W-1:0]      b_operand_address_reg,
  output oaf_pkg::oaf_mode_t          addr_mode,
  output oaf_pkg::oaf_form_t          addr_form,
  output logic [4:0]                  addr_modifier,
  output logic                        addr_done,
  output logic                        instr_too_long
);
  logic                   rst_s1_r;
  logic                   rst_n_r;
  oaf_pkg::oaf_mode_t     mode_r;
  logic [`OAF_ADDR_W-1:0] seq_r;
  logic [`OAF_ADDR_W-1:0] a_r;
  logic [`OAF_ADDR_W-1:0] b_r;
  logic [23:0]            asm_r;
  logic [1:0]             cnt_r;
  logic [3:0]             ilen_r;
  logic                   done_r;
  logic                   long_r;
  oaf_pkg::oaf_form_t     form_r;
  logic [4:0]             modf_r;

  wire [1:0]              last_idx;
  wire                    last_char;
  wire [23:0]             asm_nxt;
  wire [`OAF_ADDR_W-1:0]  load_low;
  wire [`OAF_ADDR_W-1:0]  load_mask;
  wire [`OAF_ADDR_W-1:0]  tgt_cur;
  wire [`OAF_ADDR_W-1:0]  tgt_load;
  wire [2:0]              mod3;
  wire [4:0]              mod5;
  oaf_pkg::oaf_form_t     form_dec;
  wire [4:0]              modf_dec;
  wire [3:0]              ilen_nxt;
  // Named decode wires keep the processes short
  wire                    ilen_full;
  wire                    mode_2ch;
  wire                    mode_3ch;
  wire                    mode_4ch;
  wire                    mod3_dir;
  wire                    mod3_ind;
  wire                    mod5_dir;
  wire                    mod5_ind;
  wire                    mod_plain;
  wire                    code_dir;
  wire                    code_ind;
  wire                    load_a;
  wire                    load_b;
  oaf_pkg::oaf_step_t     dir_a;
  oaf_pkg::oaf_step_t     dir_b;

  // One carrier per operand register
  oaf_step_if sa ();
  oaf_step_if sb ();

  // Reset release through two flops; async assert
  // Release is synchronous so no register leaves reset on a different edge
  // Assertion stays asynchronous so the block is quiet even without a clock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // Mode state: held until the next mode change
  // Reset mode is four-character, so the whole register loads until a mode is chosen
  // Nothing else changes the mode, so every extraction sees the last one written
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_r <= oaf_pkg::OAF_MODE_4CH;
    end else if (mode_wr) begin
      mode_r <= mode_in;
    end
  end

  // Sequence counter steps once per instruction character
  // A load wins over a fetch in the same cycle, so a branch target is never skipped
  // The counter spans all bits; instruction fetch is never confined to a bank
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      seq_r <= `OAF_RESET_ADDR;
    end else if (seq_load) begin
      seq_r <= seq_load_val;
    end else if (char_fetch) begin
      seq_r <= seq_r + 19'h00001;
    end
  end

  // Instruction length watch: more than twelve characters is flagged
  // The count saturates at twelve so a runaway fetch cannot wrap to a short length
  assign ilen_full = (ilen_r == `OAF_MAX_INSTR);
  assign ilen_nxt  = op_start ? 4'h1 : (ilen_r + 4'h1);

  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ilen_r <= 4'h0;
    end else if (char_fetch) begin
      ilen_r <= (ilen_full && !op_start) ? ilen_r : ilen_nxt;
    end
  end

  // Flag stands until the next op code character starts a new instruction
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      long_r <= 1'b0;
    end else if (char_fetch) begin
      long_r <= !op_start && ilen_full;
    end
  end

  // Mode decode shared by counting, field split and modifier decode
  assign mode_2ch = (mode_r == oaf_pkg::OAF_MODE_2CH);
  assign mode_3ch = (mode_r == oaf_pkg::OAF_MODE_3CH);
  assign mode_4ch = (mode_r == oaf_pkg::OAF_MODE_4CH);

  // Address characters assemble high first; count set by the mode
  // A mode change mid-address would move the last index; the sequencer must avoid it
  assign last_idx  = mode_2ch ? 2'h1 : (mode_3ch ? 2'h2 : 2'h3);
  assign last_char = addr_char_vld && (cnt_r == last_idx);
  assign asm_nxt   = {asm_r[17:0], addr_char};

  // Shift register clears on the last character so stale high bits never leak
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      asm_r <= 24'h000000;
    end else if (addr_char_vld) begin
      asm_r <= last_char ? 24'h000000 : asm_nxt;
    end
  end

  // Character index within the address portion
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cnt_r <= 2'h0;
    end else if (addr_char_vld) begin
      cnt_r <= last_char ? 2'h0 : (cnt_r + 2'h1);
    end
  end

  // Field split of the completed address
  assign mod3 = asm_nxt[17:15];
  assign mod5 = asm_nxt[23:19];
  assign load_low = mode_2ch ? {7'h00, asm_nxt[11:0]} :
                    mode_3ch ? {4'h0, asm_nxt[14:0]} :
                    asm_nxt[18:0];
  // Bits replaced at extraction; duplicates-A path replaces all
  // Bits outside the mask keep the bank or sector base left by earlier work
  assign load_mask = (dup_a || mode_4ch) ? 19'h7FFFF :
                     mode_2ch ? 19'h00FFF :
                     19'h07FFF;
  assign tgt_cur  = addr_sel_b ? b_r : a_r;
  assign tgt_load = (tgt_cur & ~load_mask) | (load_low & load_mask);
  assign load_a   = last_char && !addr_sel_b;
  assign load_b   = last_char && addr_sel_b;

  // Modifier code compares; any code other than the two plain forms selects indexing
  assign mod3_dir = (mod3 == `OAF_MOD3_DIRECT);
  assign mod3_ind = (mod3 == `OAF_MOD3_INDIR);
  assign mod5_dir = (mod5 == `OAF_MOD5_DIRECT);
  assign mod5_ind = (mod5 == `OAF_MOD5_INDIR);
  // Two-character mode never indexes or indirects; nor does a processor without the option
  assign mod_plain = mode_2ch || !adv_prog_en;
  assign code_dir  = mode_3ch ? mod3_dir : mod5_dir;
  assign code_ind  = mode_3ch ? mod3_ind : mod5_ind;
  assign form_dec  = (mod_plain || code_dir) ? oaf_pkg::OAF_FORM_DIRECT :
                     code_ind ? oaf_pkg::OAF_FORM_INDIRECT : oaf_pkg::OAF_FORM_INDEXED;
  // Modifier is zero-extended in three-character mode and zero in two-character mode
  assign modf_dec = mode_2ch ? 5'h00 : (mode_3ch ? {2'h0, mod3} : mod5);

  // One-cycle completion pulse after the last address character
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      done_r <= 1'b0;
    end else begin
      done_r <= last_char;
    end
  end

  // Form and modifier hold until the next address completes
  // Form reads as none after reset, so a consumer can tell no address was taken yet
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      form_r <= oaf_pkg::OAF_FORM_NONE;
      modf_r <= 5'h00;
    end else if (last_char) begin
      form_r <= form_dec;
      modf_r <= modf_dec;
    end
  end

  // Step direction per register; the executor picks it per operand kind
  // Both registers share step_up, so A and B cannot step in opposite ways in one cycle
  assign dir_a = !step_a ? oaf_pkg::OAF_STEP_NONE :
                 step_up ? oaf_pkg::OAF_STEP_UP : oaf_pkg::OAF_STEP_DOWN;
  assign dir_b = !step_b ? oaf_pkg::OAF_STEP_NONE :
                 step_up ? oaf_pkg::OAF_STEP_UP : oaf_pkg::OAF_STEP_DOWN;

  // Stepper hookups; a channel cycle widens the step to every bit
  assign sa.cur  = a_r;
  assign sa.mode = mode_r;
  assign sa.dir  = dir_a;
  assign sa.chan = chan_cycle;
  assign sb.cur  = b_r;
  assign sb.mode = mode_r;
  assign sb.dir  = dir_b;
  assign sb.chan = chan_cycle;

  // One stepper per operand register; both see the same mode and channel cycle
  oaf_stepper u_step_a (
    .s (sa.step)
  );
  oaf_stepper u_step_b (
    .s (sb.step)
  );

  // Operand registers: extraction load wins over a step in the same cycle
  // A step strobed in the load cycle is lost; the executor never overlaps the two
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      a_r <= `OAF_RESET_ADDR;
    end else begin
      a_r <= load_a ? tgt_load : sa.nxt;
    end
  end

  // B register follows the same pattern with its own stepper
  always_ff @(posedge ref_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      b_r <= `OAF_RESET_ADDR;
    end else begin
      b_r <= load_b ? tgt_load : sb.nxt;
    end
  end

  // Whole register is the operand address at execution
  // Outputs are the registers themselves, so every data output comes from a flop
  // No base is added here: the kept bank or sector bits already are the base
  assign a_operand_address_reg        = a_r;
  assign b_operand_address_reg        = b_r;
  assign instruction_sequence_counter = seq_r;
  assign addr_mode                    = mode_r;
  assign addr_form                    = form_r;
  assign addr_modifier                = modf_r;
  assign addr_done                    = done_r;
  assign instr_too_long               = long_r;
endmodule : oaf_addr_top

//--- verification/oaf_addr_properties.sv
// Concurrent checks on the ports of the operand address formation top.
// Assumes a bind into oaf_addr_top and no strobes while internal reset runs.
`timescale 1ns/1ps
`include "oaf_regs.svh"
module oaf_addr_props (
  input wire logic                   ref_clk,
  input wire logic                   resetn,
  input wire logic                   mode_wr,
  input wire oaf_pkg::oaf_mode_t     mode_in,
  input wire logic                   adv_prog_en,
  input wire logic                   seq_load,
  input wire logic [`OAF_ADDR_W-1:0] seq_load_val,
  input wire logic                   char_fetch,
  input wire logic                   addr_char_vld,
  input wire logic                   step_a,
  input wire logic                   step_b,
  input wire logic                   step_up,
  input wire logic                   chan_cycle,
  input wire logic [`OAF_ADDR_W-1:0] instruction_sequence_counter,
  input wire logic [`OAF_ADDR_W-1:0] a_operand_address_reg,
  input wire logic [`OAF_ADDR_W-1:0] b_operand_address_reg,
  input wire oaf_pkg::oaf_mode_t     addr_mode,
  input wire oaf_pkg::oaf_form_t     addr_form,
  input wire logic [4:0]             addr_modifier,
  input wire logic                   addr_done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Steps are judged only where no address load can win the cycle
  wire        quiet = !addr_char_vld && !chan_cycle;
  wire [18:0] a     = a_operand_address_reg;
  wire [18:0] b     = b_operand_address_reg;
  wire [18:0] isc   = instruction_sequence_counter;
  a_bank_wrap: assert property (step_a && !step_up && quiet && addr_mode == oaf_pkg::OAF_MODE_2CH
    |=> a[18:12] == $past(a[18:12]) && a[11:0] == $past(a[11:0]) - 12'h001)
    else $error("bank stepping wrong");
  a_sector_wrap: assert property (step_b && step_up && quiet && addr_mode == oaf_pkg::OAF_MODE_3CH
    |=> b[18:15] == $past(b[18:15]) && b[14:0] == $past(b[14:0]) + 15'h0001)
    else $error("sector stepping wrong");
  a_full_step: assert property (step_a && !addr_char_vld
    && (chan_cycle || addr_mode == oaf_pkg::OAF_MODE_4CH)
    |=> a == ($past(step_up) ? $past(a) + 19'h00001 : $past(a) - 19'h00001))
    else $error("full width step wrong");
  a_seq_count: assert property (char_fetch && !seq_load |=> isc == $past(isc) + 19'h00001)
    else $error("sequence count wrong");
  a_seq_load: assert property (seq_load |=> isc == $past(seq_load_val))
    else $error("sequence load wrong");
  a_mode_take: assert property (mode_wr |=> addr_mode == $past(mode_in))
    else $error("mode not taken");
  a_mode_hold: assert property (!mode_wr |=> $stable(addr_mode))
    else $error("mode drifted");
  a_done_pulse: assert property (addr_done |=> !addr_done)
    else $error("done longer than one cycle");
  a_short_direct: assert property (addr_done && addr_mode == oaf_pkg::OAF_MODE_2CH
    |-> addr_modifier == 5'h00 && addr_form == oaf_pkg::OAF_FORM_DIRECT)
    else $error("short address modified");
  a_mod3_indir: assert property (addr_done && adv_prog_en && addr_modifier == 5'h07
    && addr_mode == oaf_pkg::OAF_MODE_3CH |-> addr_form == oaf_pkg::OAF_FORM_INDIRECT)
    else $error("indirect code missed");
endmodule : oaf_addr_props
bind oaf_addr_top oaf_addr_props i_props (.ref_clk, .resetn, .mode_wr, .mode_in, .adv_prog_en,
  .seq_load, .seq_load_val, .char_fetch, .addr_char_vld, .step_a, .step_b, .step_up,
  .chan_cycle, .instruction_sequence_counter, .a_operand_address_reg, .b_operand_address_reg,
  .addr_mode, .addr_form, .addr_modifier, .addr_done);

//--- verification/oaf_mem_model.sv
// Character memory that feeds instruction characters to the block.
// Assumes the bench fills the array; reads answer at once, index wraps at 1024.
`timescale 1ns/1ps
module oaf_mem_model (
  input  wire logic [18:0] rd_addr,
  output logic [5:0]       rd_char
);
  logic [5:0] mem [0:1023];
  // Small store: sequence addresses alias, which is harmless for random content
  assign rd_char = mem[rd_addr[9:0]];
endmodule : oaf_mem_model

//--- verification/operand_address_formation_test.sv
// Self-checking bench for oaf_addr_top with a model of both operand registers.
// Assumes the memory model supplies each address character from the sequence counter.
`timescale 1ns/1ps
`include "oaf_regs.svh"
module operand_address_formation_test;
  logic               ref_clk, resetn, mode_wr, adv_prog_en, seq_load, char_fetch, op_start;
  logic               addr_char_vld, addr_sel_b, dup_a, step_a, step_b, step_up, chan_cycle;
  logic               addr_done, instr_too_long;
  logic [18:0]        seq_load_val, isc, a_reg, b_reg;
  logic [5:0]         mem_char;
  logic [4:0]         addr_modifier;
  oaf_pkg::oaf_mode_t mode_in, addr_mode;
  oaf_pkg::oaf_form_t addr_form;
  int                 err_count, checked, seed, mode_m, seq_m;
  int                 regs [2];
  oaf_addr_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .mode_wr(mode_wr), .mode_in(mode_in),
    .adv_prog_en(adv_prog_en), .seq_load(seq_load), .seq_load_val(seq_load_val),
    .char_fetch(char_fetch), .op_start(op_start), .addr_char_vld(addr_char_vld),
    .addr_char(mem_char), .addr_sel_b(addr_sel_b), .dup_a(dup_a), .step_a(step_a),
    .step_b(step_b), .step_up(step_up), .chan_cycle(chan_cycle),
    .instruction_sequence_counter(isc), .a_operand_address_reg(a_reg),
    .b_operand_address_reg(b_reg), .addr_mode(addr_mode), .addr_form(addr_form),
    .addr_modifier(addr_modifier), .addr_done(addr_done), .instr_too_long(instr_too_long));
  oaf_mem_model i_mem (.rd_addr(isc), .rd_char(mem_char));
  // Clock and hang guard; normal run is under eleven hundred cycles
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    err_count++;
    end_sim;
  end
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic set_mode(input int m);
    @(negedge ref_clk);
    mode_wr = 1'b1;
    mode_in = oaf_pkg::oaf_mode_t'(m);
    mode_m = m;
    @(negedge ref_clk);
    mode_wr = 1'b0;
    chk(addr_mode, mode_in);
  endtask : set_mode
  // Fetch one address portion MSB first, then compare against the model
  task automatic ld(input bit b, input bit dup);
    int v, mb, m, md, f;
    v = 0;
    adv_prog_en = $random(seed);
    for (int i = 0; i < mode_m + 2; i++) begin
      @(negedge ref_clk);
      {char_fetch, addr_char_vld, addr_sel_b, dup_a, op_start} = {2'h3, b, dup, i == 0};
      v = (v << 6) | mem_char;
    end
    @(negedge ref_clk);
    {char_fetch, op_start, addr_char_vld} = 3'h0;
    seq_m += mode_m + 2;
    mb = (mode_m == 0) ? 12 : (mode_m == 1 ? 15 : 19);
    m = (1 << mb) - 1;
    md = v >> mb;
    regs[b] = (dup || mode_m == 2) ? (v & m) : ((regs[b] & ~m & 'h7FFFF) | (v & m));
    f = (!adv_prog_en || md == 0) ? 0 : (md == (mode_m == 1 ? 7 : 16) ? 1 : 2);
    chk(addr_done, 1'b1);
    chk(b ? b_reg : a_reg, regs[b]);
    chk(addr_modifier, md);
    chk(addr_form, f);
    chk(isc, seq_m);
  endtask : ld
  // Back-to-back steps; width of the wrap follows mode and channel cycle
  task automatic step(input int r, input bit up, input bit ch, input int k);
    int m;
    for (int i = 0; i < k; i++) begin
      @(negedge ref_clk);
      {step_a, step_b, step_up, chan_cycle} = {r == 0, r == 1, up, ch};
      m = (ch || mode_m == 2) ? 'h7FFFF : (mode_m == 0 ? 'hFFF : 'h7FFF);
      regs[r] = (regs[r] & ~m & 'h7FFFF) | ((regs[r] + (up ? 1 : -1)) & m);
    end
    @(negedge ref_clk);
    {step_a, step_b, chan_cycle} = 3'h0;
    chk(r ? b_reg : a_reg, regs[r]);
  endtask : step
  initial begin
    {mode_wr, adv_prog_en, seq_load, char_fetch, op_start, addr_char_vld} = 6'h00;
    {addr_sel_b, dup_a, step_a, step_b, step_up, chan_cycle} = 6'h00;
    mode_in = oaf_pkg::OAF_MODE_4CH;
    seq_load_val = 19'h00000;
    {err_count, checked, seq_m, mode_m, seed} = {32'd0, 32'd0, 32'd0, 32'd2, 32'd7967};
    regs = '{0, 0};
    for (int i = 0; i < 1024; i++) i_mem.mem[i] = $random(seed);
    resetn = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(addr_form, oaf_pkg::OAF_FORM_NONE);
    chk(a_reg, 19'h00000);
    $display("reset test done");
    // Zero address in each mode, then borrow below zero
    for (int t = 0; t < 3; t++) begin
      set_mode(t);
      for (int i = 0; i < 4; i++) i_mem.mem[768 + i] = 6'h00;
      @(negedge ref_clk);
      {seq_load, seq_load_val, seq_m} = {1'b1, 19'h00300, 32'h300};
      @(negedge ref_clk);
      seq_load = 1'b0;
      ld(0, 0);
      step(0, 0, 0, 2);
      step(0, 0, 1, 1);
      step(0, 1, 0, 3);
    end
    $display("wrap test done");
    // Twelve fetches after an op code overrun the longest instruction
    for (int i = 0; i < 14; i++) begin
      @(negedge ref_clk);
      if (i == 12) chk(instr_too_long, 1'b0);
      if (i == 13) chk(instr_too_long, 1'b1);
      {char_fetch, op_start} = {1'b1, i == 0 || i == 13};
    end
    @(negedge ref_clk);
    {char_fetch, op_start} = 2'h0;
    seq_m += 14;
    chk(instr_too_long, 1'b0);
    chk(isc, seq_m);
    $display("length test done");
    for (int i = 0; i < 80; i++) begin
      if ($random(seed) % 4 == 0) set_mode({$random(seed)} % 3);
      ld($random(seed), $random(seed));
      step($random(seed) & 1, $random(seed), $random(seed), 1 + {$random(seed)} % 4);
    end
    $display("random test done");
    end_sim;
  end
endmodule : operand_address_formation_test
